/* File: pbsc_dev_model.sv */
// Behavioural device model: serial register port, band search and lock
`timescale 1ns/1ps
`default_nettype none
module pbsc_dev_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // Scenario controls
  input  wire logic [5:0]  auto_band_i,
  input  wire logic [15:0] lock_dly_i,
  input  wire logic        pin_en_i,
  input  wire logic        ref_ok_i,
  // Device pins
  input  wire logic        sclk_i,
  input  wire logic        csb_b_i,
  input  wire logic        sdio_i,
  output logic             sdio_o,
  output logic             lock_pin_o
);
  logic [7:0]  band_r, div_r, bw_r, rd_r, wd;
  logic [15:0] sh_r, tmr_r;
  logic [4:0]  cnt_r, wa;
  logic        lock_r, auto_r, saw_auto_r, rw_r, oe_r, bit_r, sclk_q, float_r;
  assign wa = sh_r[11:7];
  assign wd = {sh_r[6:0], sdio_i};
  // Released line toggles so a stale bit is never read as valid
  assign sdio_o = oe_r ? bit_r : float_r;
  assign lock_pin_o = lock_r & pin_en_i;
  function automatic logic [7:0] rd_mux(input logic [4:0] a);
    case (a)
      5'h00:   return {6'h00, lock_r, 1'h0};
      5'h08:   return band_r;
      5'h09:   return div_r;
      5'h0A:   return bw_r;
      default: return 8'h00;
    endcase
  endfunction
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {band_r, div_r, bw_r, rd_r, sh_r, tmr_r, cnt_r} <= '0;
      {lock_r, auto_r, saw_auto_r, rw_r, oe_r, bit_r, sclk_q, float_r} <= '0;
    end else begin
      sclk_q  <= sclk_i;
      float_r <= ~float_r;
      // Search only advances while the reference runs
      if (auto_r && ref_ok_i) begin
        tmr_r <= tmr_r - 16'h0001;
        if (tmr_r == 16'h0000) begin
          lock_r      <= 1'b1;
          auto_r      <= 1'b0;
          band_r[7:2] <= auto_band_i;
        end
      end
      if (csb_b_i) begin
        cnt_r <= '0;
        oe_r  <= 1'b0;
      end else if (sclk_i && !sclk_q) begin
        sh_r  <= {sh_r[14:0], sdio_i};
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r == 5'h07) begin
          rw_r <= sh_r[6];
          rd_r <= rd_mux({sh_r[3:0], sdio_i});
        end
        if (cnt_r == 5'h0F && !sh_r[14]) begin
          case (wa)
            5'h08: begin
              band_r     <= wd;
              auto_r     <= wd[7:2] == 6'h3F;
              lock_r     <= wd[7:2] != 6'h3F;
              tmr_r      <= lock_dly_i;
              saw_auto_r <= saw_auto_r | (wd[7:2] == 6'h3F);
            end
            5'h09: begin
              div_r      <= wd;
              saw_auto_r <= 1'b0;
            end
            5'h0A:   bw_r <= wd;
            default: ;
          endcase
        end
      end else if (!sclk_i && sclk_q && rw_r && cnt_r >= 5'h08) begin
        oe_r  <= 1'b1;
        bit_r <= rd_r[7];
        rd_r  <= {rd_r[6:0], 1'h0};
      end
    end
  end
endmodule
`default_nettype wire

/* File: pbsc_host.sv */
// Host that runs band search, temperature correction and band reload
`timescale 1ns/1ps
`default_nettype none

module pbsc_host #(
  parameter int LOCK_CYC = pbsc_pkg::LOCK_CYC
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  // User command
  input  wire logic              start_i,
  input  wire pbsc_pkg::pbsc_mode_t mode_i,
  input  wire logic signed [7:0] temp_i,
  input  wire logic [1:0]        first_loop_divider_i,
  input  wire logic [1:0]        second_loop_divider_i,
  input  wire logic [5:0]        band_i,
  // User status
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   fail_o,
  output logic [5:0]             band_o,
  // Nonvolatile store
  output logic                   nvm_wr_o,
  output logic [5:0]             nvm_band_o,
  // Device pins
  input  wire logic              ref_ok_i,
  input  wire logic              lock_pin_i,
  output logic                   sclk_o,
  output logic                   csb_b_o,
  output logic                   sdio_o,
  output logic                   sdio_oe_o,
  input  wire logic              sdio_i
);

  pbsc_pkg::pbsc_state_t st_r;
  pbsc_pkg::pbsc_mode_t  mode_r;
  pbsc_pkg::pbsc_frame_t frame;
  logic [2:0]            sync1_r;
  logic [2:0]            sync2_r;
  logic                  lock_s;
  logic                  sdio_s;
  logic                  ref_s;
  logic signed [7:0]     temp_r;
  logic [1:0]            div1_r;
  logic [1:0]            div2_r;
  logic [5:0]            band_r;
  logic [3:0]            div_cnt_r;
  logic                  tick;
  logic                  xf_busy_r;
  logic                  xf_done_r;
  logic                  xf_rd_r;
  logic [15:0]           sh_r;
  logic [4:0]            bit_r;
  logic [7:0]            rx_r;
  logic                  sclk_r;
  logic                  csb_b_r;
  logic                  oe_r;
  logic                  xf_start;
  logic                  cmd_st;
  logic                  poll_lock;
  logic [31:0]           lock_cnt_r;
  logic                  busy_r;
  logic                  done_r;
  logic                  fail_r;
  logic [5:0]            band_out_r;
  logic                  nvm_wr_r;

  // Clamp a band so the automatic code is never written back
  function automatic logic [5:0] pbsc_clamp(input logic signed [8:0] v);
    if (v < 9'sd0)
      return 6'h00;
    else if (v > $signed({3'b000, pbsc_pkg::BAND_MAX}))
      return pbsc_pkg::BAND_MAX;
    else
      return v[5:0];
  endfunction
  function automatic logic [5:0] pbsc_correct(input logic [5:0] rb,
                                              input logic signed [7:0] t);
    logic signed [8:0] ofs;
    ofs = 9'sd0;
    if (t > pbsc_pkg::TEMP_P55)
      ofs = -9'sd1;
    else if (t >= pbsc_pkg::TEMP_P15)
      ofs = 9'sd0;
    else if (t >= pbsc_pkg::TEMP_M10)
      ofs = 9'sd1;
    else if (rb >= pbsc_pkg::BAND_HI_BASE && t < pbsc_pkg::TEMP_M30)
      ofs = 9'sd3;
    else
      ofs = 9'sd2;
    return pbsc_clamp($signed({3'b000, rb}) + ofs);
  endfunction

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {ref_ok_i, sdio_i, lock_pin_i};
      sync2_r <= sync1_r;
    end
  end
  assign lock_s = sync2_r[0];
  assign sdio_s = sync2_r[1];
  assign ref_s  = sync2_r[2];

  // Serial clock divider, free only while a frame is on the wire
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      div_cnt_r <= 4'h0;
    else if (!xf_busy_r || tick)
      div_cnt_r <= 4'h0;
    else
      div_cnt_r <= div_cnt_r + 4'h1;
  end
  assign tick = xf_busy_r && (div_cnt_r == 4'(pbsc_pkg::SCLK_HALF - 1));
  assign cmd_st = (st_r == pbsc_pkg::S_LBW) || (st_r == pbsc_pkg::S_DIV) ||
                  (st_r == pbsc_pkg::S_AUTO) || (st_r == pbsc_pkg::S_POLL) ||
                  (st_r == pbsc_pkg::S_RDBAND) || (st_r == pbsc_pkg::S_FIX);
  assign xf_start = cmd_st && ref_s && !xf_busy_r && !xf_done_r &&
                    !(st_r == pbsc_pkg::S_POLL && lock_s);
  always_comb begin
    frame = '0;
    unique case (st_r)
      pbsc_pkg::S_LBW: begin
        frame.addr = pbsc_pkg::ADDR_LOOP_BW;
        frame.data = {3'b000, pbsc_pkg::LOOP_BW_NOM};
      end
      pbsc_pkg::S_DIV: begin
        frame.addr = pbsc_pkg::ADDR_LOOP_DIV;
        frame.data = {1'b0, div1_r, div2_r, pbsc_pkg::LOOP_BIAS_NOM};
      end
      pbsc_pkg::S_AUTO: begin
        frame.addr = pbsc_pkg::ADDR_BAND_SELECT;
        frame.data = {pbsc_pkg::BAND_AUTO, pbsc_pkg::VCO_DRV_NOM};
      end
      pbsc_pkg::S_POLL: begin
        frame.rd   = 1'b1;
        frame.addr = pbsc_pkg::ADDR_DEV_STATUS;
      end
      pbsc_pkg::S_RDBAND: begin
        frame.rd   = 1'b1;
        frame.addr = pbsc_pkg::ADDR_BAND_SELECT;
      end
      pbsc_pkg::S_FIX: begin
        frame.addr = pbsc_pkg::ADDR_BAND_SELECT;
        frame.data = {band_r, pbsc_pkg::VCO_DRV_NOM};
      end
      default: frame = '0;
    endcase
  end

  // Three-wire engine: launch on falling SCLK, sample on rising SCLK
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xf_busy_r <= 1'b0;
      xf_done_r <= 1'b0;
      xf_rd_r   <= 1'b0;
      sh_r      <= 16'h0000;
      bit_r     <= 5'h00;
      rx_r      <= 8'h00;
      sclk_r    <= 1'b0;
      csb_b_r   <= 1'b1;
      oe_r      <= 1'b0;
    end else begin
      xf_done_r <= 1'b0;
      if (xf_start) begin
        xf_busy_r <= 1'b1;
        xf_rd_r   <= frame.rd;
        sh_r      <= frame;
        bit_r     <= 5'h00;
        csb_b_r   <= 1'b0;
        oe_r      <= 1'b1;
      end else if (tick && !sclk_r) begin
        sclk_r <= 1'b1;
        rx_r   <= {rx_r[6:0], sdio_s};
      end else if (tick) begin
        sclk_r <= 1'b0;
        sh_r   <= {sh_r[14:0], 1'b0};
        bit_r  <= bit_r + 5'h01;
        // Release the line so the device can answer a read
        if (xf_rd_r && bit_r == 5'(pbsc_pkg::INSTR_BITS - 1))
          oe_r <= 1'b0;
        if (bit_r == 5'(pbsc_pkg::FRAME_BITS - 1)) begin
          xf_busy_r <= 1'b0;
          xf_done_r <= 1'b1;
          csb_b_r   <= 1'b1;
          oe_r      <= 1'b0;
        end
      end
    end
  end

  assign poll_lock = lock_s || (xf_done_r && rx_r[pbsc_pkg::LOCK_BIT]);
  // Lock wait timer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      lock_cnt_r <= 32'h0000_0000;
    else if (st_r != pbsc_pkg::S_POLL)
      lock_cnt_r <= 32'h0000_0000;
    else
      lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
  end
  // Sequencer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r   <= pbsc_pkg::S_IDLE;
      mode_r <= pbsc_pkg::MODE_SENSE;
      temp_r <= 8'sh00;
      div1_r <= 2'h0;
      div2_r <= 2'h0;
      band_r <= 6'h00;
    end else begin
      unique case (st_r)
        pbsc_pkg::S_IDLE, pbsc_pkg::S_DONE, pbsc_pkg::S_FAIL: begin
          // A new start waits for the line to go idle after an abort
          if (start_i && !xf_busy_r) begin
            st_r   <= pbsc_pkg::S_LBW;
            mode_r <= mode_i;
            temp_r <= temp_i;
            div1_r <= first_loop_divider_i;
            div2_r <= second_loop_divider_i;
            band_r <= pbsc_clamp($signed({3'b000, band_i}));
          end
        end
        pbsc_pkg::S_LBW:
          if (xf_done_r)
            st_r <= pbsc_pkg::S_DIV;
        pbsc_pkg::S_DIV:
          if (xf_done_r)
            st_r <= (mode_r == pbsc_pkg::MODE_RELOAD || mode_r == pbsc_pkg::MODE_FIXED) ?
                    pbsc_pkg::S_FIX : pbsc_pkg::S_AUTO;
        pbsc_pkg::S_AUTO:
          if (xf_done_r)
            st_r <= pbsc_pkg::S_POLL;
        pbsc_pkg::S_POLL:
          if (poll_lock && !xf_busy_r)
            st_r <= pbsc_pkg::S_RDBAND;
          else if (lock_cnt_r >= 32'(LOCK_CYC))
            st_r <= pbsc_pkg::S_FAIL;
        pbsc_pkg::S_RDBAND:
          if (xf_done_r) begin
            band_r <= pbsc_correct(rx_r[7:pbsc_pkg::BAND_LSB], temp_r);
            st_r   <= pbsc_pkg::S_FIX;
          end
        pbsc_pkg::S_FIX:
          if (xf_done_r)
            st_r <= pbsc_pkg::S_DONE;
        default:
          st_r <= pbsc_pkg::S_IDLE;
      endcase
      // Losing the reference makes any band result meaningless
      if (cmd_st && !ref_s)
        st_r <= pbsc_pkg::S_FAIL;
    end
  end

  // User-facing status
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      fail_r     <= 1'b0;
      band_out_r <= 6'h00;
      nvm_wr_r   <= 1'b0;
    end else begin
      busy_r   <= cmd_st;
      done_r   <= (st_r == pbsc_pkg::S_DONE);
      fail_r   <= (st_r == pbsc_pkg::S_FAIL);
      nvm_wr_r <= (st_r == pbsc_pkg::S_FIX) && xf_done_r &&
                  (mode_r == pbsc_pkg::MODE_FACTORY);
      if (st_r == pbsc_pkg::S_FIX && xf_done_r)
        band_out_r <= band_r;
    end
  end
  assign busy_o     = busy_r;
  assign done_o     = done_r;
  assign fail_o     = fail_r;
  assign band_o     = band_out_r;
  assign nvm_wr_o   = nvm_wr_r;
  assign nvm_band_o = band_out_r;
  assign sclk_o     = sclk_r;
  assign csb_b_o    = csb_b_r;
  assign sdio_o     = sh_r[15];
  assign sdio_oe_o  = oe_r;
  a_div_fields: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    xf_start && st_r == pbsc_pkg::S_DIV |=> sh_r[6:5] == div1_r && sh_r[4:3] == div2_r)
    else $error("divider fields wrong in frame");
  a_nominal_bw: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    xf_start && st_r == pbsc_pkg::S_LBW |=> sh_r[4:0] == pbsc_pkg::LOOP_BW_NOM)
    else $error("loop bandwidth not nominal");
  a_auto_code: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    xf_start && st_r == pbsc_pkg::S_AUTO |=> sh_r[7:2] == pbsc_pkg::BAND_AUTO)
    else $error("auto band code not sent");
  a_lock_timeout: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_r == pbsc_pkg::S_POLL && !poll_lock && ref_s && lock_cnt_r >= 32'(LOCK_CYC)
    |=> st_r == pbsc_pkg::S_FAIL ##1 fail_o)
    else $error("lock timeout not reported");
  a_no_auto_fix: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    xf_start && st_r == pbsc_pkg::S_FIX |=> sh_r[7:2] != pbsc_pkg::BAND_AUTO)
    else $error("auto code written as fixed band");
  a_mild_keep: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_r == pbsc_pkg::S_RDBAND && xf_done_r && temp_r >= pbsc_pkg::TEMP_P15 &&
    temp_r <= pbsc_pkg::TEMP_P55 && rx_r[7:2] != pbsc_pkg::BAND_AUTO
    |=> band_r == $past(rx_r[7:2]))
    else $error("mild temperature changed band");
  a_cold_high: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_r == pbsc_pkg::S_RDBAND && xf_done_r && temp_r < pbsc_pkg::TEMP_M30 &&
    rx_r[7:2] >= pbsc_pkg::BAND_HI_BASE && rx_r[7:2] < 6'h3C
    |=> band_r == $past(rx_r[7:2]) + 6'h03)
    else $error("cold high band not raised by three");
  a_ref_abort: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    cmd_st && !ref_s |=> st_r == pbsc_pkg::S_FAIL)
    else $error("reference loss not aborted");
  a_temp_latch: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_r == pbsc_pkg::S_IDLE && start_i && !xf_busy_r |=> temp_r == $past(temp_i))
    else $error("temperature not captured");
  a_nvm_store: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_r == pbsc_pkg::S_FIX && xf_done_r && mode_r == pbsc_pkg::MODE_FACTORY && ref_s
    |=> nvm_wr_o && nvm_band_o == band_r ##1 !nvm_wr_o)
    else $error("factory band not stored");
endmodule
`default_nettype wire

/* File: pbsc_host_tb_top.sv */
// Self-checking bench for the band-select calibration host
`timescale 1ns/1ps
`default_nettype none
module pbsc_host_tb_top;
  localparam int LOCK_T = 2000;
  logic                 core_clk, rst_b, start, busy, done, fail, nvm_wr, pin_en;
  logic                 ref_ok, lock_pin, sclk, csb_b, sdio, sdio_oe, line, dev_sdo;
  pbsc_pkg::pbsc_mode_t mode;
  logic signed [7:0]    temp;
  logic [1:0]           div1, div2;
  logic [5:0]           band, band_o, nvm_band, auto_band, nvm_val;
  logic [15:0]          lock_dly;
  int                   error_cnt, n_checks, nvm_cnt, nvm_base, n;
  int                   rbs[12] = '{10, 31, 10, 20, 10, 0, 40, 32, 40, 40, 50, 62};
  int                   tps[12] = '{-20, -10, 15, 55, 56, 60, -31, -30, -10, 30, 56, -35};
  int                   exs[12] = '{12, 32, 10, 20, 9, 0, 43, 34, 41, 40, 49, 62};
  assign line = sdio_oe ? sdio : dev_sdo;
  pbsc_host #(.LOCK_CYC(LOCK_T)) dut (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .start_i(start), .mode_i(mode), .temp_i(temp),
    .first_loop_divider_i(div1), .second_loop_divider_i(div2), .band_i(band),
    .busy_o(busy), .done_o(done), .fail_o(fail), .band_o(band_o), .nvm_wr_o(nvm_wr),
    .nvm_band_o(nvm_band), .ref_ok_i(ref_ok), .lock_pin_i(lock_pin), .sclk_o(sclk),
    .csb_b_o(csb_b), .sdio_o(sdio), .sdio_oe_o(sdio_oe), .sdio_i(line));
  pbsc_dev_model dev (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .auto_band_i(auto_band), .lock_dly_i(lock_dly),
    .pin_en_i(pin_en), .ref_ok_i(ref_ok), .sclk_i(sclk), .csb_b_i(csb_b), .sdio_i(line),
    .sdio_o(dev_sdo), .lock_pin_o(lock_pin));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (nvm_wr === 1'b1) begin
      nvm_cnt++;
      nvm_val = nvm_band;
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks made: %0d, mismatches: %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Line may still finish a frame after a failure, so each run waits first
  task automatic run(input pbsc_pkg::pbsc_mode_t m, input int t, input int b, input int rb,
                     input int dly);
    repeat (400) @(posedge core_clk);
    #1;
    mode = m;
    temp = 8'(t);
    band = 6'(b);
    auto_band = 6'(rb);
    lock_dly = 16'(dly);
    div1 = auto_band[1:0];
    div2 = auto_band[3:2];
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    temp = 8'sh64;
    repeat (4) @(posedge core_clk);
    // Busy only while the sequence runs; a missing reference aborts at once
    check({7'h0, busy}, {7'h0, ref_ok}, "busy");
    n = 0;
    while (done !== 1'b1 && fail !== 1'b1 && n < 40000) begin
      @(posedge core_clk);
      n++;
    end
    #1;
    if (n >= 40000) begin
      error_cnt++;
      $display("[FAIL] %0t run timed out", $time);
      close_out();
    end
  endtask
  task automatic check_band(input int ex);
    check({7'h0, done}, 8'h01, "done");
    check({6'h0, busy, fail}, 8'h00, "idle");
    check({2'h0, band_o}, 8'(ex), "band_o");
    check(dev.band_r, 8'(ex * 4 + 3), "band field");
    check(dev.div_r, {1'h0, div1, div2, 3'h3}, "divider");
    check(dev.bw_r, 8'h0F, "bandwidth");
  endtask
  initial begin
    {rst_b, start, pin_en, div1, div2, band, auto_band, lock_dly} = '0;
    ref_ok = 1'b1;
    mode = pbsc_pkg::MODE_SENSE;
    temp = 8'sh00;
    {error_cnt, n_checks} = '0;
    repeat (4) @(posedge core_clk);
    #1 rst_b = 1'b1;
    ref_ok = 1'b0;
    run(pbsc_pkg::MODE_FIXED, 25, 61, 0, 0);
    check({6'h0, done, fail}, 8'h01, "no ref");
    ref_ok = 1'b1;
    pin_en = 1'b1;
    run(pbsc_pkg::MODE_SENSE, 25, 0, 10, 60000);
    check({6'h0, done, fail}, 8'h01, "lock fail");
    check({7'h0, (n >= LOCK_T) && (n < LOCK_T + 2000)}, 8'h01, "lock wait");
    for (int i = 0; i < 12; i++) begin
      pin_en = i[0];
      nvm_base = nvm_cnt;
      run(i % 3 == 0 ? pbsc_pkg::MODE_FACTORY : pbsc_pkg::MODE_SENSE, tps[i], 0, rbs[i],
          200 + 100 * i);
      check_band(exs[i]);
      check({7'h0, dev.saw_auto_r}, 8'h01, "auto code");
      check(8'(nvm_cnt - nvm_base), i % 3 == 0 ? 8'h01 : 8'h00, "store count");
      if (i % 3 == 0) check({2'h0, nvm_val}, 8'(exs[i]), "stored band");
    end
    run(pbsc_pkg::MODE_RELOAD, 25, exs[0], 0, 0);
    check_band(exs[0]);
    check({7'h0, dev.saw_auto_r}, 8'h00, "no search");
    run(pbsc_pkg::MODE_FIXED, 25, 61, 0, 0);
    check_band(61);
    run(pbsc_pkg::MODE_FIXED, 25, 63, 0, 0);
    check_band(62);
    close_out();
  end
endmodule
`default_nettype wire

/* File: pbsc_pkg.sv */
// Constants, types and frame layout for the band-select calibration host
package pbsc_pkg;

  // Device register offsets
  localparam logic [4:0] ADDR_DEV_STATUS  = 5'h00;
  localparam logic [4:0] ADDR_BAND_SELECT = 5'h08;
  localparam logic [4:0] ADDR_LOOP_DIV    = 5'h09;
  localparam logic [4:0] ADDR_LOOP_BW     = 5'h0A;

  // Field positions
  localparam int LOCK_BIT  = 1;
  localparam int BAND_LSB  = 2;
  localparam int DIV1_LSB  = 5;
  localparam int DIV2_LSB  = 3;

  // Band codes and nominal loop settings
  localparam logic [5:0] BAND_AUTO    = 6'h3F;
  localparam logic [5:0] BAND_MAX     = 6'h3E;
  localparam logic [5:0] BAND_HI_BASE = 6'h20;
  localparam logic [4:0] LOOP_BW_NOM  = 5'h0F;
  localparam logic [1:0] VCO_DRV_NOM  = 2'h3;
  localparam logic [2:0] LOOP_BIAS_NOM = 3'h3;

  // Temperature breakpoints in degrees C
  localparam logic signed [7:0] TEMP_M30 = -8'sd30;
  localparam logic signed [7:0] TEMP_M10 = -8'sd10;
  localparam logic signed [7:0] TEMP_P15 = 8'sd15;
  localparam logic signed [7:0] TEMP_P55 = 8'sd55;

  // Timing
  localparam int CLK_KHZ      = 200000;
  localparam int LOCK_WAIT_MS = 5;
  localparam int LOCK_CYC     = LOCK_WAIT_MS * CLK_KHZ;
  localparam int SCLK_KHZ     = 10000;
  localparam int SCLK_HALF    = CLK_KHZ / (2 * SCLK_KHZ);
  localparam int FRAME_BITS   = 16;
  localparam int INSTR_BITS   = 8;

  typedef enum logic [1:0] {
    MODE_SENSE,
    MODE_FACTORY,
    MODE_RELOAD,
    MODE_FIXED
  } pbsc_mode_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_LBW,
    S_DIV,
    S_AUTO,
    S_POLL,
    S_RDBAND,
    S_FIX,
    S_DONE,
    S_FAIL
  } pbsc_state_t;

  // One serial frame: instruction byte then data byte, MSB first
  typedef struct packed {
    logic       rd;
    logic [1:0] pad;
    logic [4:0] addr;
    logic [7:0] data;
  } pbsc_frame_t;

endpackage
